// *** eds_pkg.sv ***
package eds_pkg;
   // divider-select code layout
   localparam int          CODE_W           = 4;
   localparam int          NUM_BANDS        = 16;
   localparam int          EDGE_SEL_POS     = 3;
   localparam int          RATIO_IDX_W      = 3;
   // each ratio step multiplies by 8, i.e. shifts by 3
   localparam int          RATIO_STEP_SHIFT = 3;
   // wide enough for the largest ratio, 2^21
   localparam int          DELAY_CNT_W      = 22;
   localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;
   // timing
   localparam int          CLK_PERIOD_NS    = 25;
   localparam int          MASTER_PERIOD_NS = 1000;
   localparam int          STARTUP_PERIODS  = 500;
   localparam int          STARTUP_CNT_W    = 10;
   // operating states, one-hot
   typedef enum logic [2:0] {
      EDS_START = 3'b001,
      EDS_IDLE  = 3'b010,
      EDS_TIME  = 3'b100
   } eds_state_t;
endpackage

// *** eds_code_if.sv ***
`timescale 1ns/1ps
interface eds_code_if;
   logic [3:0] code;
   modport src (output code);
   modport dst (input code);
endinterface

// *** eds_code_quant.sv ***
`timescale 1ns/1ps
module eds_code_quant
   import eds_pkg::*;
#(
   parameter int LEVEL_W = 8
) (
   input  wire logic               clock_i,
   input  wire logic               rst_n_i,
   input  wire logic [LEVEL_W-1:0] ratio_level_i,
   input  wire logic [LEVEL_W-1:0] supply_level_i,
   eds_code_if.src                 code_if
);
   initial begin
      if (LEVEL_W < 4 || LEVEL_W > 24) begin
         $error("eds_code_quant: LEVEL_W out of range");
      end
   end

   logic [CODE_W-1:0]    code_reg;
   logic [CODE_W-1:0]    code_next;
   logic [LEVEL_W+3:0]   scaled;
   logic [LEVEL_W+3:0]   thresh;

   // [RULE6] equal supply bands
   // band count: number of k in 1..15 with 16*ratio >= k*supply
   always_comb begin
      code_next = CODE_W'(0);
      scaled    = {ratio_level_i, 4'h0};
      thresh    = '0;
      for (int k = 1; k < NUM_BANDS; k++) begin
         thresh = (LEVEL_W+4)'(k) * (LEVEL_W+4)'(supply_level_i);
         if (scaled >= thresh) begin
            code_next = CODE_W'(k);
         end
      end
   end

   // register the quantised code
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         code_reg <= CODE_RESET;
      end else begin
         code_reg <= code_next;
      end
   end

   assign code_if.code = code_reg;
endmodule

// *** eds_edge_delay.sv ***
`timescale 1ns/1ps
// Summary of operation
// [RULE1] delay equals selected ratio 1..2^21 times one master period
// [RULE2] ratio-pin level is quantised against supply into a 4-bit code
// [RULE3] the code sets the division ratio used while timing
// [RULE4] code msb is the edge-select bit, low three bits pick the ratio
// [RULE5] codes 0..7 ascend through ratios, codes 8..15 mirror them
// [RULE6] code bands are sixteen equal slices of the supply
// [RULE7] single-edge variant delays only one transition direction
// [RULE8] single-edge: bit 0 delays rising, bit 1 delays falling edges
// [RULE9] dual-edge variant delays both rising and falling transitions
// [RULE10] dual-edge: bit 1 inverts the output, bit 0 does not
// [RULE11] a transition to be delayed starts the master oscillator
// [RULE12] output changes only after the programmed delay has elapsed
// [RULE13] delays from 1 us to 33.6 s are supported; the ratios here stop at 2^21 master periods, about 2.1 s
// [RULE14] transitions shorter than the delay never reach the output
// [RULE15] input reverting abandons timing; next transition restarts it
// [RULE16] single-edge: the undelayed direction passes through at once
// [RULE17] after reset output held low, input ignored for 500 periods
// [RULE18] end of start-up copies input to output, inverted if configured
// [RULE19] delay timer counts master periods, cleared on input transition
// [RULE20] timed input is synchronised before edge detection
module eds_edge_delay
   import eds_pkg::*;
#(
   parameter bit DUAL_EDGE         = 1'b0,
   parameter int MASTER_PERIOD_NSP = MASTER_PERIOD_NS,
   parameter int STARTUP_COUNT     = STARTUP_PERIODS,
   parameter int LEVEL_W           = 8
) (
   input  wire logic               clock_i,
   input  wire logic               rst_n_i,
   input  wire logic               timed_in_i,
   input  wire logic [LEVEL_W-1:0] ratio_level_i,
   input  wire logic [LEVEL_W-1:0] supply_level_i,
   output logic                    delayed_out_o,
   output logic [3:0]              divider_select_code_o,
   output logic                    edge_select_bit_o,
   output logic                    timing_active_o,
   output logic                    ready_o
);
   // master period in clock cycles, rounded up
   localparam int MASTER_CYC = (MASTER_PERIOD_NSP + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRE_W      = $clog2(MASTER_CYC + 1);

   initial begin
      if (MASTER_CYC < 1 || STARTUP_COUNT < 1 || STARTUP_COUNT >= (1 << STARTUP_CNT_W)) begin
         $error("eds_edge_delay: timing parameters out of range");
      end
   end

   eds_code_if code_if ();

   // [RULE2] band quantiser
   eds_code_quant #(
      .LEVEL_W (LEVEL_W)
   ) u_quant (
      .clock_i        (clock_i),
      .rst_n_i        (rst_n_i),
      .ratio_level_i  (ratio_level_i),
      .supply_level_i (supply_level_i),
      .code_if        (code_if)
   );

   eds_state_t               state_reg, state_next;
   logic                     sync1_reg, sync2_reg, prev_reg;
   logic [CODE_W-1:0]        code_reg;
   logic [PRE_W-1:0]         pre_reg, pre_next;
   logic [STARTUP_CNT_W-1:0] start_reg, start_next;
   // [RULE13] counter spans 2^21
   logic [DELAY_CNT_W-1:0]   delay_reg, delay_next;
   logic                     out_reg, out_next;
   logic                     tick;
   logic                     edge_sel;
   logic [RATIO_IDX_W-1:0]   ratio_idx;
   logic [4:0]               ratio_shift;
   logic [DELAY_CNT_W-1:0]   ratio;
   logic                     target;
   logic                     delayed_dir;
   logic                     in_edge;
   logic                     active_next, ready_next;

   // [RULE4] split code into edge-select bit and ratio index
   assign edge_sel    = code_reg[EDGE_SEL_POS];
   // [RULE5] mirror upper half of the codes
   assign ratio_idx   = edge_sel ? ~code_reg[RATIO_IDX_W-1:0] : code_reg[RATIO_IDX_W-1:0];
   // [RULE3] ratio = 8^index
   assign ratio_shift = 5'(ratio_idx) * 5'(RATIO_STEP_SHIFT);
   assign ratio       = DELAY_CNT_W'(1) << ratio_shift;
   // [RULE1] master period tick
   assign tick        = (pre_reg == PRE_W'(MASTER_CYC - 1));
   // [RULE10] dual-edge output level, inverted when edge-select set
   assign target      = DUAL_EDGE ? (sync2_reg ^ edge_sel) : sync2_reg;
   // [RULE7] one direction only
   // [RULE9] dual delays both
   // [RULE8] single-edge direction selected by the edge-select bit
   assign delayed_dir = DUAL_EDGE | (target != edge_sel);
   assign in_edge     = sync2_reg ^ prev_reg;

   // next state of sequencer, timers and output
   always_comb begin
      state_next = state_reg;
      pre_next   = pre_reg;
      start_next = start_reg;
      delay_next = delay_reg;
      out_next   = out_reg;
      case (state_reg)
         EDS_START: begin
            // [RULE17] output low, input ignored
            out_next = 1'b0;
            pre_next = tick ? PRE_W'(0) : pre_reg + PRE_W'(1);
            if (tick) begin
               if (start_reg == STARTUP_CNT_W'(STARTUP_COUNT - 1)) begin
                  // [RULE18] copy input level without delay
                  out_next   = target;
                  state_next = EDS_IDLE;
               end else begin
                  start_next = start_reg + STARTUP_CNT_W'(1);
               end
            end
         end
         EDS_IDLE: begin
            pre_next   = PRE_W'(0);
            delay_next = DELAY_CNT_W'(0);
            if (target != out_reg) begin
               if (delayed_dir) begin
                  // [RULE11] start master oscillator
                  state_next = EDS_TIME;
               end else begin
                  // [RULE16] undelayed direction passes at once
                  out_next = target;
               end
            end
         end
         EDS_TIME: begin
            if (target == out_reg) begin
               // [RULE14] short pulse filtered
               // [RULE15] input reverted, abandon timing
               state_next = EDS_IDLE;
               pre_next   = PRE_W'(0);
               delay_next = DELAY_CNT_W'(0);
            end else if (in_edge) begin
               // [RULE19] clear timer on input transition
               pre_next   = PRE_W'(0);
               delay_next = DELAY_CNT_W'(0);
            end else begin
               pre_next = tick ? PRE_W'(0) : pre_reg + PRE_W'(1);
               if (tick) begin
                  // [RULE12] output follows only after full ratio of periods
                  if (delay_reg >= ratio - DELAY_CNT_W'(1)) begin
                     out_next   = target;
                     state_next = EDS_IDLE;
                  end else begin
                     delay_next = delay_reg + DELAY_CNT_W'(1);
                  end
               end
            end
         end
         default: begin
            state_next = EDS_START;
            out_next   = 1'b0;
         end
      endcase
   end

   // [RULE20] two-stage input synchroniser
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         sync1_reg <= timed_in_i;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg; // edge history, reads only the second stage
      end
   end

   // code taken from the quantiser, one clock behind it
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         code_reg <= CODE_RESET;
      end else begin
         code_reg <= code_if.code;
      end
   end

   // sequencer, prescaler, start-up and delay counters
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_reg <= EDS_START;
         pre_reg   <= '0;
         start_reg <= '0;
         delay_reg <= '0;
         out_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         pre_reg   <= pre_next;
         start_reg <= start_next;
         delay_reg <= delay_next;
         out_reg   <= out_next;
      end
   end

   // status levels, taken from the next state so they line up with the output
   always_comb begin
      active_next = (state_next == EDS_TIME);
      ready_next  = (state_next != EDS_START);
   end

   // registered outputs, each straight from a flop
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         delayed_out_o         <= 1'b0;
         divider_select_code_o <= CODE_RESET;
         edge_select_bit_o     <= 1'b0;
         timing_active_o       <= 1'b0;
         ready_o               <= 1'b0;
      end else begin
         delayed_out_o         <= out_next;
         divider_select_code_o <= code_reg;
         edge_select_bit_o     <= edge_sel;
         timing_active_o       <= active_next;
         ready_o               <= ready_next;
      end
   end
endmodule

// *** eds_edge_delay_props.sv ***
`timescale 1ns/1ps
module eds_edge_delay_props
   import eds_pkg::*;
#(
   parameter int MASTER_PERIOD_NSP = 1000,
   parameter int STARTUP_COUNT     = 500,
   parameter int LEVEL_W           = 8
) (
   input wire logic               clock_i,
   input wire logic               rst_n_i,
   input wire logic               timed_in_i,
   input wire logic [LEVEL_W-1:0] ratio_level_i,
   input wire logic [LEVEL_W-1:0] supply_level_i,
   input wire logic               delayed_out_o,
   input wire logic [3:0]         divider_select_code_o,
   input wire logic               edge_select_bit_o,
   input wire logic               timing_active_o,
   input wire logic               ready_o
);
   localparam int MC = (MASTER_PERIOD_NSP + 24) / 25;
   localparam int SU = STARTUP_COUNT * MC;
   logic [31:0] run_next, run_reg, up_next, up_reg, need;
   logic [2:0]  idx;
   logic        rise_ok;
   logic        rdy_d_reg;
   // length of the timing run, clocks from reset until ready, expected run length
   always_comb begin
      run_next = timing_active_o ? run_reg + 32'h1 : 32'h0;
      up_next  = ready_o ? up_reg : up_reg + 32'h1;
      idx      = edge_select_bit_o ? ~divider_select_code_o[2:0] : divider_select_code_o[2:0];
      need     = MC << (3 * idx);
      rise_ok  = rdy_d_reg && !edge_select_bit_o;
   end
   always_ff @(posedge clock_i) begin
      run_reg <= rst_n_i ? run_next : 32'h0;
      up_reg  <= rst_n_i ? up_next : 32'h0;
      // ready level one clock back, keeps the start-up edge out of the delay checks
      rdy_d_reg <= rst_n_i ? ready_o : 1'b0;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_reset_clears_out: assert property ($rose(rst_n_i) |-> !delayed_out_o && !ready_o)
      else $error("outputs not cleared by reset");
   a_startup_out_low: assert property (!ready_o |-> !delayed_out_o && !timing_active_o)
      else $error("output moved during start-up");
   a_ready_holds: assert property (ready_o |=> ready_o)
      else $error("ready dropped");
   a_startup_len_ok: assert property ($rose(ready_o) |-> up_reg >= SU - 2 && up_reg <= SU + 3)
      else $error("start-up length wrong");
   a_pol_is_msb: assert property (edge_select_bit_o == divider_select_code_o[3])
      else $error("edge select bit not code msb");
   a_delay_len_ok: assert property ($rose(delayed_out_o) && rise_ok |-> run_reg >= need - 1 && run_reg <= need + 3)
      else $error("delay length wrong");
   a_rise_after_timer: assert property ($rose(delayed_out_o) && rise_ok |-> $past(timing_active_o))
      else $error("rising edge not timed");
   a_fall_passes_direct: assert property ($fell(delayed_out_o) && !edge_select_bit_o |-> !$past(timing_active_o))
      else $error("falling edge was timed");
   a_rise_passes_direct: assert property ($rose(delayed_out_o) && $past(ready_o) && edge_select_bit_o
      |-> !$past(timing_active_o))
      else $error("rising edge timed with bit set");
   c_fall_delayed: cover property ($fell(delayed_out_o) && edge_select_bit_o);
   c_abandoned: cover property ($fell(timing_active_o) && !$changed(delayed_out_o));
   c_start_high: cover property ($rose(ready_o) && delayed_out_o);
endmodule
bind eds_edge_delay eds_edge_delay_props #(.MASTER_PERIOD_NSP(MASTER_PERIOD_NSP), .STARTUP_COUNT(STARTUP_COUNT),
   .LEVEL_W(LEVEL_W)) eds_edge_delay_props_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .timed_in_i(timed_in_i),
   .ratio_level_i(ratio_level_i), .supply_level_i(supply_level_i), .delayed_out_o(delayed_out_o),
   .divider_select_code_o(divider_select_code_o), .edge_select_bit_o(edge_select_bit_o),
   .timing_active_o(timing_active_o), .ready_o(ready_o));

// *** eds_switch_model.sv ***
`timescale 1ns/1ps
// switch source: follows level_i, chatters every 20 clocks while bounce_i is high
module eds_switch_model (
   input  wire logic clock_i,
   input  wire logic level_i,
   input  wire logic bounce_i,
   output logic      sw_o
);
   logic [4:0] tick_reg = 5'h0;
   logic       chat_reg = 1'b0;
   // free-running chatter, moves on the falling edge like the rest of the stimulus
   always @(negedge clock_i) begin
      tick_reg <= (tick_reg == 5'h13) ? 5'h0 : tick_reg + 5'h1;
      if (tick_reg == 5'h13) chat_reg <= ~chat_reg;
   end
   assign sw_o = bounce_i ? chat_reg : level_i;
endmodule

// *** programmable_edge_delay_test.sv ***
`timescale 1ns/1ps
module programmable_edge_delay_test;
   import eds_pkg::*;
   localparam int MC = 2;
   logic       clock_i = 0, rst_n_i = 0, lvl = 1, bnc = 0, timed_in_i;
   logic [7:0] ratio_level_i = 8'h05, supply_level_i = 8'ha0;
   logic       delayed_out_o, edge_select_bit_o, timing_active_o, ready_o;
   logic [3:0] divider_select_code_o;
   int         bad_count = 0, tests_run = 0;
   always #12.5 clock_i = ~clock_i;
   eds_switch_model eds_switch_model_inst (.clock_i(clock_i), .level_i(lvl), .bounce_i(bnc), .sw_o(timed_in_i));
   eds_edge_delay #(.MASTER_PERIOD_NSP(50), .STARTUP_COUNT(4)) eds_edge_delay_inst (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .timed_in_i(timed_in_i), .ratio_level_i(ratio_level_i), .supply_level_i(supply_level_i),
      .delayed_out_o(delayed_out_o), .divider_select_code_o(divider_select_code_o),
      .edge_select_bit_o(edge_select_bit_o), .timing_active_o(timing_active_o), .ready_o(ready_o));
   task check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         bad_count++;
         $display("ERROR %0t: got %0h want %0h", $time, seen, want);
      end
   endtask
   task conclude;
      if (bad_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // clocks until the output reaches v
   task wait_out(input logic v, output int n);
      n = 0;
      while (delayed_out_o !== v && n < 400) begin
         @(negedge clock_i);
         n++;
      end
   endtask
   task set_code(input int c);
      ratio_level_i = 8'(10 * c + 5);
      repeat (5) @(negedge clock_i);
   endtask
   task t_startup;
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      check(ready_o, 1);
      check(delayed_out_o, 1);
   endtask
   task t_codes;
      for (int c = 0; c < 16; c++) begin
         set_code(c);
         check(divider_select_code_o, c);
         check(edge_select_bit_o, c >> 3);
      end
   endtask
   task t_delay(input int c);
      int   n, e;
      logic b;
      b = 1'(c >> 3);
      e = MC * (8 ** (b ? 7 - c % 8 : c % 8));
      set_code(c);
      lvl = b;
      repeat (e + 20) @(negedge clock_i);
      lvl = ~b;
      wait_out(~b, n);
      check(n >= e + 2 && n <= e + 6, 1);
      lvl = b;
      wait_out(b, n);
      check(n >= 3 && n <= 5, 1);
   endtask
   task t_filter;
      int   n;
      logic hit;
      hit = 0;
      set_code(2);
      lvl = 0;
      repeat (10) @(negedge clock_i);
      bnc = 1;
      lvl = 1;
      repeat (200) begin
         @(negedge clock_i);
         hit = hit | delayed_out_o;
      end
      check(hit, 0);
      // hold the input low long enough for the synchroniser to see it, abandoning any timing
      bnc = 0;
      lvl = 0;
      repeat (4) @(negedge clock_i);
      lvl = 1;
      repeat (4) @(negedge clock_i);
      check(timing_active_o, 1);
      wait_out(1, n);
      check(n >= MC * 64 - 2 && n <= MC * 64 + 2, 1);
   endtask
   initial begin
      #(25 * 20000);
      bad_count++;
      conclude;
   end
   initial begin
      repeat (4) @(negedge clock_i);
      rst_n_i = 1;
      t_startup;
      t_codes;
      for (int i = 0; i < 6; i++) t_delay(i < 3 ? i : 18 - i);
      t_filter;
      conclude;
   end
endmodule
